//--- common/i2c_regs_consts.vh
// constants for the i2c status and control register block
`ifndef I2C_REGS_CONSTS_VH
`define I2C_REGS_CONSTS_VH

// register byte offsets
`define OFF_BUS_STATUS 12'h000
`define OFF_BUS_CONTROL 12'h004
`define OFF_CLOCK_CONTROL 12'h008
`define OFF_TRANSFER_DATA 12'h00c
`define OFF_OWN_ADDR 12'h010
`define OFF_IRQ_STATUS 12'h014
`define OFF_IRQ_CLEAR 12'h018
`define OFF_IRQ_ENABLE 12'h01c

// bus_control field positions
`define BC_BUS_ERR 7
`define BC_BUS_ERR_IE 6
`define BC_RESTART 5
`define BC_MASTER_SEL 4
`define BC_ACK 3
`define BC_GC_ACK 2
`define BC_DONE_IE 1
`define BC_INT 0

// clock_control_reg field positions
`define CC_HSM 6
`define CC_EN 5

// irq status bit positions
`define IRQ_DONE 0
`define IRQ_BERR 1
`define IRQ_ARB 2

// reset values
`define RST_BUS_STATUS 8'h00
`define RST_BUS_CONTROL 8'h00
`define RST_CLOCK_CONTROL 8'h80
`define RST_OWN_ADDR 7'h00

// timing: i2c system clock period versus core clock period
`define CORE_PERIOD_NS 10
`define I2C_SYS_PERIOD_NS 60
`define SYS_CYCLES (`I2C_SYS_PERIOD_NS / `CORE_PERIOD_NS)
`define M_STD_BASE 7'h41
`define GEN_CALL_ADDR 7'h00

`endif

//--- src/bit_sync.v
// two flip-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/100ps
module bit_sync #(
	parameter WIDTH = 2
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// asynchronous in, synchronised out
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_sync
			reg meta_ff;
			reg stable_ff;
			// idle bus level is high, so reset to one
			always @(posedge core_clk) begin
				if (!rst_n) begin
					meta_ff <= 1'b1;
					stable_ff <= 1'b1;
				end else begin
					meta_ff <= async_in[gi];
					stable_ff <= meta_ff;
				end
			end
			assign sync_out[gi] = stable_ff;
		end
	endgenerate
endmodule // bit_sync

//--- src/half_period_div.v
// divider giving a one-cycle tick every half serial clock period
`timescale 1ns/100ps
module half_period_div (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// control
	input wire run,
	input wire [11:0] half_cycles,
	// tick enable
	output wire tick
);
	reg [11:0] cnt_ff;
	wire [11:0] nxt_cnt;

	assign tick = run && (cnt_ff >= half_cycles);
	assign nxt_cnt = (!run || tick) ? 12'h000 : cnt_ff + 12'h001;

	// count core cycles, restart on each tick
	always @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_ff <= 12'h000;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule // half_period_div

//--- src/i2c_status_control_regs.v
// i2c controller: status and control registers, byte engine, apb slave
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`include "i2c_regs_consts.vh"

module i2c_status_control_regs (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata_ff,
	// i2c pins, open drain
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	// interrupt
	output wire irq
);
	localparam M_IDLE = 3'h0;
	localparam M_START = 3'h1;
	localparam M_LOW = 3'h2;
	localparam M_HIGH = 3'h3;
	localparam M_STOP1 = 3'h4;
	localparam M_STOP2 = 3'h5;
	localparam M_RS1 = 3'h6;
	localparam M_RS2 = 3'h7;

	// bus status bits
	reg busy_ff, rpt_start_ff, arb_lost_ff, last_ack_ff;
	reg tx_dir_ff, addressed_ff, gen_call_ff, first_byte_ff;
	// bus control bits
	reg bus_err_ff, bus_err_ie_ff, master_sel_ff, ack_ff, gc_ack_en_ff, done_ie_ff, intf_ff;
	// clock control bits
	reg hsm_ff, en_ff;
	reg [4:0] cs_ff;
	reg [7:0] data_ff;
	reg [6:0] own_addr_ff;
	reg [2:0] irq_stat_ff, irq_en_ff;
	// byte engine and master sequencer
	reg [7:0] shift_ff;
	reg [3:0] bit_cnt_ff;
	reg eng_sda_ff, m_sda_ff, m_scl_ff, m_rd_ff;
	reg pend_stop_ff, pend_rs_ff;
	reg [2:0] mst_state_ff;
	reg scl_d_ff, sda_d_ff;

	wire scl_s, sda_s, tick;
	wire master = (mst_state_ff != M_IDLE);

	bit_sync #(.WIDTH(2)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in({scl_in, sda_in}),
		.sync_out({scl_s, sda_s})
	);

	// half period in core cycles from the period select code
	wire [6:0] m_std = `M_STD_BASE + {2'b00, cs_ff};
	wire [6:0] m_hs = {2'b00, cs_ff} + 7'h01;
	wire [7:0] m_hs15 = {1'b0, m_hs} + {2'b00, m_hs[6:1]};
	wire [7:0] half_units = hsm_ff ? {1'b0, m_hs15[7:1]} : {1'b0, m_std};
	wire [31:0] half_prod = {24'h000000, half_units} * `SYS_CYCLES;
	wire [11:0] half_cycles = half_prod[11:0]; // at most 96 units of 6 cycles

	half_period_div u_div (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.run(en_ff),
		.half_cycles(half_cycles),
		.tick(tick)
	);

	// bus condition and clock edge detection on synchronised pins
	always @(posedge core_clk) begin
		if (!rst_n) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end
	wire scl_rise = scl_s && !scl_d_ff;
	wire scl_fall = !scl_s && scl_d_ff;
	wire start_det = en_ff && scl_s && scl_d_ff && sda_d_ff && !sda_s;
	wire stop_det = en_ff && scl_s && scl_d_ff && !sda_d_ff && sda_s;
	// a repeated start or stop sits in the first clock of a frame
	wire mid_byte = (bit_cnt_ff > 4'h1);
	wire bus_err = (start_det || stop_det) && mid_byte;

	// apb decode, zero wait states
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire hit = (paddr[1:0] == 2'b00) && (paddr[11:5] == 7'h00);
	assign pready = 1'b1;
	assign pslverr = acc && !hit;
	wire wr_bc = wr && (paddr == `OFF_BUS_CONTROL);
	wire wr_cc = wr && (paddr == `OFF_CLOCK_CONTROL);
	wire w_int0 = wr_bc && !pwdata[`BC_INT];
	wire w_master = pwdata[`BC_MASTER_SEL];
	wire w_restart = pwdata[`BC_RESTART];
	// software commands derived from a bus_control write
	wire req_start = wr_bc && w_master && !master_sel_ff && en_ff;
	wire go_start = req_start && !busy_ff;
	wire arb_busy = req_start && busy_ff;
	wire req_stop = w_int0 && !w_master && master_sel_ff;
	wire req_rs = w_int0 && w_restart && w_master && master_sel_ff;
	wire resume = w_int0 && !req_stop && !req_rs;

	// byte events on clock edges
	wire own_byte = master || addressed_ff;
	wire addr_bit = scl_rise && (bit_cnt_ff == 4'h7) && first_byte_ff && !master;
	wire addr_match = (shift_ff[6:0] == own_addr_ff);
	wire gc_match = (shift_ff[6:0] == `GEN_CALL_ADDR) && gen_call_match_en;
	// only a data bit sent by the master can lose, not its own stop or restart
	wire arb_lost = scl_rise && (mst_state_ff == M_HIGH) && tx_dir_ff && !bit_cnt_ff[3]
		&& !eng_sda_ff && !sda_s;
	wire byte_end = scl_fall && (bit_cnt_ff == 4'h9);
	wire int_set = byte_end && (own_byte || gen_call_ff);
	wire arb_set = arb_lost || arb_busy;
	wire gen_call_match_en = gc_ack_en_ff;

	// open drain outputs: pins only ever pulled low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = m_scl_ff || (intf_ff && addressed_ff);
	assign sda_oe = m_sda_ff || eng_sda_ff;

	// master sequencer: start, clock generation, stop, repeated start
	always @(posedge core_clk) begin
		if (!rst_n) begin
			mst_state_ff <= M_IDLE;
			m_sda_ff <= 1'b0;
			m_scl_ff <= 1'b0;
		end else if (!en_ff || bus_err || arb_lost) begin
			mst_state_ff <= M_IDLE;
			m_sda_ff <= 1'b0;
			m_scl_ff <= 1'b0;
		end else begin
			case (mst_state_ff)
				M_IDLE: begin
					if (go_start) begin
						m_sda_ff <= 1'b1;
						mst_state_ff <= M_START;
					end
				end
				M_START: begin
					if (tick) begin
						m_scl_ff <= 1'b1;
						m_sda_ff <= 1'b0;
						mst_state_ff <= M_LOW;
					end
				end
				M_LOW: begin
					if (tick && pend_stop_ff) begin
						m_sda_ff <= 1'b1;
						mst_state_ff <= M_STOP1;
					end else if (tick && pend_rs_ff) begin
						mst_state_ff <= M_RS1;
					end else if (tick && !intf_ff) begin
						m_scl_ff <= 1'b0;
						mst_state_ff <= M_HIGH;
					end
				end
				M_HIGH: begin
					if (tick && scl_s) begin
						m_scl_ff <= 1'b1;
						mst_state_ff <= M_LOW;
					end
				end
				M_STOP1: begin
					if (tick) begin
						m_scl_ff <= 1'b0;
						mst_state_ff <= M_STOP2;
					end
				end
				M_STOP2: begin
					if (tick && scl_s) begin
						m_sda_ff <= 1'b0;
						mst_state_ff <= M_IDLE;
					end
				end
				M_RS1: begin
					if (tick) begin
						m_scl_ff <= 1'b0;
						mst_state_ff <= M_RS2;
					end
				end
				M_RS2: begin
					if (tick && scl_s) begin
						m_sda_ff <= 1'b1;
						mst_state_ff <= M_START;
					end
				end
				default: begin
					mst_state_ff <= M_IDLE;
				end
			endcase
		end
	end

	// reset images, sliced onto the flag groups
	wire [7:0] rst_bs = `RST_BUS_STATUS;
	wire [7:0] rst_bc = `RST_BUS_CONTROL;
	wire [7:0] rst_cc = `RST_CLOCK_CONTROL;

	// status flags, control bits and byte engine
	always @(posedge core_clk) begin
		if (!rst_n) begin
			{busy_ff, rpt_start_ff, arb_lost_ff, last_ack_ff} <= rst_bs[7:4];
			{tx_dir_ff, addressed_ff, gen_call_ff, first_byte_ff} <= rst_bs[3:0];
			{bus_err_ff, bus_err_ie_ff, master_sel_ff, ack_ff} <= {rst_bc[7:6], rst_bc[4:3]};
			{gc_ack_en_ff, done_ie_ff, intf_ff} <= rst_bc[2:0];
			{hsm_ff, en_ff, cs_ff} <= rst_cc[6:0];
			data_ff <= 8'h00;
			own_addr_ff <= `RST_OWN_ADDR;
			shift_ff <= 8'h00;
			bit_cnt_ff <= 4'h0;
			eng_sda_ff <= 1'b0;
			m_rd_ff <= 1'b0;
			pend_stop_ff <= 1'b0;
			pend_rs_ff <= 1'b0;
		end else begin
			// software writes; bus_status is read only
			if (wr_cc) begin
				{hsm_ff, en_ff, cs_ff} <= pwdata[6:0];
			end
			if (wr && (paddr == `OFF_TRANSFER_DATA)) begin
				data_ff <= pwdata[7:0];
			end
			if (wr && (paddr == `OFF_OWN_ADDR)) begin
				own_addr_ff <= pwdata[6:0];
			end
			if (wr_bc) begin
				bus_err_ie_ff <= pwdata[`BC_BUS_ERR_IE];
				ack_ff <= pwdata[`BC_ACK];
				gc_ack_en_ff <= pwdata[`BC_GC_ACK];
				done_ie_ff <= pwdata[`BC_DONE_IE];
				if (!pwdata[`BC_BUS_ERR]) begin
					bus_err_ff <= 1'b0;
				end
				if (!w_master) begin
					master_sel_ff <= 1'b0;
				end
			end
			if (go_start) begin
				master_sel_ff <= 1'b1;
				m_rd_ff <= data_ff[0];
				shift_ff <= data_ff;
				tx_dir_ff <= 1'b1;
			end
			if (req_stop) begin
				pend_stop_ff <= 1'b1;
			end
			if (req_rs) begin
				pend_rs_ff <= 1'b1;
				m_rd_ff <= data_ff[0];
			end
			if (w_int0) begin
				intf_ff <= 1'b0;
				arb_lost_ff <= 1'b0;
				rpt_start_ff <= 1'b0;
				first_byte_ff <= 1'b0;
			end
			if (resume && tx_dir_ff && own_byte) begin
				shift_ff <= data_ff;
				eng_sda_ff <= !data_ff[7];
			end
			// sample on rising clock
			if (scl_rise && !bit_cnt_ff[3]) begin
				shift_ff <= {shift_ff[6:0], sda_s};
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end
			if (scl_rise && (bit_cnt_ff == 4'h8)) begin
				last_ack_ff <= sda_s;
				bit_cnt_ff <= 4'h9;
			end
			if (addr_bit && addr_match) begin
				addressed_ff <= 1'b1;
			end
			if (addr_bit && gc_match && !sda_s) begin
				gen_call_ff <= 1'b1;
			end
			if (addr_bit && !addr_match && !(gc_match && !sda_s)) begin
				first_byte_ff <= 1'b0;
				rpt_start_ff <= 1'b0;
			end
			// drive data and acknowledge on falling clock
			if (scl_fall && !bit_cnt_ff[3]) begin
				eng_sda_ff <= tx_dir_ff && own_byte && !shift_ff[7];
			end
			if (scl_fall && (bit_cnt_ff == 4'h8)) begin
				if (tx_dir_ff) begin
					eng_sda_ff <= 1'b0;
				end else if (first_byte_ff && !master) begin
					eng_sda_ff <= addressed_ff || gen_call_ff;
				end else begin
					eng_sda_ff <= ack_ff && (own_byte || gen_call_ff);
				end
			end
			if (byte_end) begin
				bit_cnt_ff <= 4'h0;
				eng_sda_ff <= 1'b0;
				if (first_byte_ff && master) begin
					tx_dir_ff <= !m_rd_ff;
				end else if (first_byte_ff && addressed_ff) begin
					tx_dir_ff <= shift_ff[0];
				end
			end
			if (int_set) begin
				intf_ff <= 1'b1;
			end
			if (arb_set) begin
				arb_lost_ff <= 1'b1;
				intf_ff <= 1'b1;
			end
			if (arb_lost) begin
				master_sel_ff <= 1'b0;
				tx_dir_ff <= 1'b0;
				eng_sda_ff <= 1'b0;
			end
			// start and stop conditions
			if (start_det) begin
				busy_ff <= 1'b1;
				rpt_start_ff <= busy_ff;
				first_byte_ff <= 1'b1;
				{last_ack_ff, addressed_ff, gen_call_ff} <= 3'b000;
				bit_cnt_ff <= 4'h0;
				pend_rs_ff <= 1'b0;
				if (!master) begin
					tx_dir_ff <= 1'b0;
				end
				if (master) begin
					intf_ff <= 1'b0;
				end
			end
			if (stop_det) begin
				busy_ff <= 1'b0;
				{rpt_start_ff, last_ack_ff, addressed_ff, gen_call_ff} <= 4'h0;
				tx_dir_ff <= 1'b0;
				bit_cnt_ff <= 4'h0;
				eng_sda_ff <= 1'b0;
				pend_stop_ff <= 1'b0;
				master_sel_ff <= 1'b0;
				if (master) begin
					intf_ff <= 1'b0;
				end
			end
			if (bus_err) begin
				bus_err_ff <= 1'b1;
				en_ff <= 1'b0;
			end
			// disabled: status and control clear except error bits
			if (!en_ff) begin
				{busy_ff, rpt_start_ff, arb_lost_ff, last_ack_ff} <= 4'h0;
				{tx_dir_ff, addressed_ff, gen_call_ff, first_byte_ff} <= 4'h0;
				{master_sel_ff, ack_ff, gc_ack_en_ff, done_ie_ff, intf_ff} <= 5'h00;
				bit_cnt_ff <= 4'h0;
				eng_sda_ff <= 1'b0;
				pend_stop_ff <= 1'b0;
				pend_rs_ff <= 1'b0;
			end
		end
	end

	// sticky event status, write-one clear, set wins
	wire [2:0] irq_ev;
	assign irq_ev[`IRQ_DONE] = int_set;
	assign irq_ev[`IRQ_BERR] = bus_err;
	assign irq_ev[`IRQ_ARB] = arb_set;
	wire [2:0] irq_clr = (wr && (paddr == `OFF_IRQ_CLEAR)) ? pwdata[2:0] : 3'b000;
	always @(posedge core_clk) begin
		if (!rst_n) begin
			irq_stat_ff <= 3'b000;
			irq_en_ff <= 3'b000;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
			if (wr && (paddr == `OFF_IRQ_ENABLE)) begin
				irq_en_ff <= pwdata[2:0];
			end
		end
	end
	assign irq = |(irq_stat_ff & irq_en_ff) || (done_ie_ff && intf_ff)
		|| (bus_err_ie_ff && bus_err_ff);

	// read mux, captured in the setup phase
	reg [7:0] rd_val;
	always @* begin
		rd_val = 8'h00;
		case (paddr)
			`OFF_BUS_STATUS: rd_val = en_ff ? {busy_ff, rpt_start_ff, arb_lost_ff, last_ack_ff,
				tx_dir_ff, addressed_ff, gen_call_ff, first_byte_ff} : 8'h00;
			`OFF_BUS_CONTROL: rd_val = {bus_err_ff, bus_err_ie_ff, 1'b0, master_sel_ff, ack_ff,
				gc_ack_en_ff, done_ie_ff, intf_ff};
			`OFF_CLOCK_CONTROL: rd_val = {1'b1, hsm_ff, en_ff, cs_ff};
			`OFF_TRANSFER_DATA: rd_val = shift_ff;
			`OFF_OWN_ADDR: rd_val = {1'b0, own_addr_ff};
			`OFF_IRQ_STATUS: rd_val = {5'h00, irq_stat_ff};
			`OFF_IRQ_ENABLE: rd_val = {5'h00, irq_en_ff};
			default: rd_val = 8'h00;
		endcase
	end
	always @(posedge core_clk) begin
		if (!rst_n) begin
			prdata_ff <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= {24'h000000, rd_val};
		end
	end
endmodule // i2c_status_control_regs

//--- tb/i2c_status_control_regs_monitor.sv
// port-level assertions for the i2c register block
`timescale 1ns/100ps
module i2c_status_control_regs_monitor (
	// clock, reset, apb
	input wire core_clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata_ff,
	// i2c pins and interrupt
	input wire scl_in,
	input wire scl_out,
	input wire scl_oe,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	reg en_ff;
	wire acc = psel && penable;
	wire rd = acc && !pwrite;
	wire ctl = rd && paddr == 12'h004;
	wire bad = paddr > 12'h01c || paddr[1:0] != 2'h0;
	// enable bit as software last wrote it
	always @(posedge core_clk) begin
		if (!rst_n)
			en_ff <= 1'b0;
		else if (acc && pwrite && paddr == 12'h008)
			en_ff <= pwdata[5];
	end
	a_ready_high: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (acc && bad |-> pslverr && (pwrite || prdata_ff == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && !bad |-> !pslverr) else $error("mapped access refused");
	a_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
	a_upper_zero: assert property (rd |-> prdata_ff[31:8] == 24'h0) else $error("upper bits set");
	a_off_clear: assert property (rd && paddr == 12'h000 && !en_ff |-> prdata_ff[7:0] == 8'h00)
		else $error("status not clear while disabled");
	a_done_stretch: assert property (ctl && prdata_ff[4] && prdata_ff[0] |-> scl_oe [*2])
		else $error("scl not held while done");
	a_berr_irq: assert property (ctl && prdata_ff[7] && prdata_ff[6] |-> irq)
		else $error("bus error irq missing");
	a_done_irq: assert property (ctl && prdata_ff[1] && prdata_ff[0] |-> irq)
		else $error("done irq missing");
	a_pins_zero: assert property (!scl_out && !sda_out) else $error("pin driven high");
endmodule // i2c_status_control_regs_monitor
bind i2c_status_control_regs i2c_status_control_regs_monitor mon (.core_clk(core_clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata_ff(prdata_ff),
	.scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

//--- tb/i2c_bus_partner.sv
// behavioural i2c master on the far side of the pins
`timescale 1ns/100ps
module i2c_bus_partner (
	// resolved lines
	input wire scl,
	input wire sda,
	// pulls, high drags the line low
	output logic scl_low,
	output logic sda_low
);
	logic lclk = 1'b0;
	// set when a released scl never comes back high
	logic hung = 1'b0;
	// link pace, 80 ns period, phase unrelated to core clock
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		#3;
		forever #40 lclk = ~lclk;
	end
	task step;
		@(lclk);
	endtask
	// release scl and wait out stretching
	task rise;
		integer n;
		scl_low = 1'b0;
		for (n = 0; n < 400 && scl !== 1'b1; n++)
			step;
		if (scl !== 1'b1)
			hung = 1'b1;
		step;
	endtask
	// start or repeated start
	task start;
		sda_low = 1'b0;
		step;
		rise;
		sda_low = 1'b1;
		step;
		scl_low = 1'b1;
		step;
	endtask
	// stop
	task stop;
		sda_low = 1'b1;
		step;
		rise;
		sda_low = 1'b0;
		step;
	endtask
	// one bit, sampled at end of high phase
	task xfer(input logic b, output logic s);
		sda_low = !b;
		step;
		rise;
		s = sda;
		scl_low = 1'b1;
		step;
	endtask
	// byte msb first, then ack slot
	task send(input logic [7:0] v, output logic ack);
		logic s;
		integer i;
		for (i = 7; i >= 0; i--)
			xfer(v[i], s);
		xfer(1'b1, ack);
	endtask
endmodule // i2c_bus_partner

//--- tb/tb_i2c_status_control_regs.sv
// self-checking bench for the i2c register block
`timescale 1ns/100ps
module tb_i2c_status_control_regs;
	logic core_clk, rst_n, psel, penable, pwrite, serr, far_scl_low, far_sda_low;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	wire [31:0] prdata_ff;
	wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
	integer err_total, cmp_count;
	// open-drain lines with pull-ups
	wire scl = !(scl_oe || far_scl_low);
	wire sda = !(sda_oe || far_sda_low);
	i2c_status_control_regs dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata_ff(prdata_ff), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .irq(irq));
	i2c_bus_partner far (.scl(scl), .sda(sda), .scl_low(far_scl_low), .sda_low(far_sda_low));
	task give_verdict;
		chk_pin("link", 1'b0, far.hung);
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task bail;
		err_total++;
		give_verdict;
	endtask
	task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task chk_pin(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %b got %b", nm, e, g);
		end
	endtask
	// one apb transfer held until pready
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q);
		integer n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata_ff;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			bail;
		#1;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task rd(input string nm, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] q;
		apb(1'b0, a, 8'h00, q);
		chk_reg(nm, e, q[7:0] & m);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		logic a;
		logic [31:0] q;
		integer n;
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		err_total = 0;
		cmp_count = 0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		// reset values and refusal
		rd("st", 12'h000, 8'hff, 8'h00);
		rd("ctl", 12'h004, 8'hff, 8'h00);
		rd("clk", 12'h008, 8'hff, 8'h80);
		rd("bad", 12'h020, 8'hff, 8'h00);
		chk_pin("pslverr", 1'b1, serr);
		far.start;
		rd("st", 12'h000, 8'hff, 8'h00);
		far.stop;
		$display("t1 end");
		// busy, first byte, read-only status, arbitration
		wr(12'h008, 8'h20);
		wr(12'h010, 8'h2a);
		far.start;
		rd("st", 12'h000, 8'hff, 8'h81);
		wr(12'h000, 8'h00);
		rd("st", 12'h000, 8'hff, 8'h81);
		wr(12'h004, 8'h10);
		rd("st", 12'h000, 8'h20, 8'h20);
		wr(12'h004, 8'h00);
		rd("st", 12'h000, 8'h20, 8'h00);
		far.stop;
		rd("st", 12'h000, 8'h80, 8'h00);
		$display("t2 end");
		// addressed as slave, stretch, repeated start
		far.start;
		far.send(8'h54, a);
		chk_pin("ack", 1'b0, a);
		rd("st", 12'h000, 8'hff, 8'h85);
		rd("ctl", 12'h004, 8'h01, 8'h01);
		chk_pin("scl_oe", 1'b1, scl_oe);
		wr(12'h004, 8'h00);
		chk_pin("scl_oe", 1'b0, scl_oe);
		rd("st", 12'h000, 8'h01, 8'h00);
		far.start;
		rd("st", 12'h000, 8'hd5, 8'hc1);
		far.stop;
		rd("st", 12'h000, 8'hd6, 8'h00);
		$display("t3 end");
		// general call
		wr(12'h004, 8'h04);
		far.start;
		far.send(8'h00, a);
		rd("st", 12'h000, 8'h02, 8'h02);
		wr(12'h004, 8'h04);
		far.start;
		rd("st", 12'h000, 8'h02, 8'h00);
		far.stop;
		$display("t4 end");
		// stop in mid-byte, interrupt raise, mask, clear
		wr(12'h004, 8'h40);
		far.start;
		for (n = 0; n < 3; n++)
			far.xfer(1'b1, a);
		far.stop;
		rd("ctl", 12'h004, 8'hc0, 8'hc0);
		rd("clk", 12'h008, 8'h20, 8'h00);
		chk_pin("irq", 1'b1, irq);
		rd("ist", 12'h014, 8'h02, 8'h02);
		wr(12'h004, 8'h00);
		rd("ctl", 12'h004, 8'h80, 8'h00);
		chk_pin("irq", 1'b0, irq);
		wr(12'h01c, 8'h02);
		chk_pin("irq", 1'b1, irq);
		wr(12'h018, 8'h02);
		chk_pin("irq", 1'b0, irq);
		rd("ist", 12'h014, 8'h02, 8'h00);
		$display("t5 end");
		// master transmit with no acknowledge, then stop
		wr(12'h008, 8'h20);
		wr(12'h00c, 8'h54);
		wr(12'h004, 8'h12);
		for (n = 0; n < 30000 && irq !== 1'b1; n++)
			@(posedge core_clk);
		if (n >= 30000)
			bail;
		rd("st", 12'h000, 8'h98, 8'h98);
		rd("ctl", 12'h004, 8'h13, 8'h13);
		chk_pin("scl_oe", 1'b1, scl_oe);
		wr(12'h004, 8'h00);
		n = 0;
		do
			apb(1'b0, 12'h000, 8'h00, q);
		while (q[7] !== 1'b0 && ++n < 1000);
		chk_reg("busy", 8'h00, q[7:0] & 8'h80);
		$display("t6 end");
		give_verdict;
	end
endmodule // tb_i2c_status_control_regs
